//--- rtl/pcmsp_pkg.sv
// Package: constants and types for the PCM codec serial port
package pcmsp_pkg;
  localparam int PCMSP_WORD_BITS   = 8;
  localparam int PCMSP_FIFO_DEPTH  = 8;
  localparam int PCMSP_SYNC_STAGES = 2;
  // Master clock watchdog: no edge for this many ns = static level
  localparam int PCMSP_MCLK_IDLE_NS = 4000;
  localparam int PCMSP_CLK_NS       = 100;
  localparam int PCMSP_MCLK_IDLE_CYC = (PCMSP_MCLK_IDLE_NS + PCMSP_CLK_NS - 1) / PCMSP_CLK_NS;
  // Reset values
  localparam logic [7:0] PCMSP_TX_RESET = 8'h00;
  localparam logic [7:0] PCMSP_RX_RESET = 8'h00;

  typedef logic [PCMSP_WORD_BITS-1:0] pcmsp_word_t;

  typedef enum logic [1:0] {
    PCMSP_RXCK_RUN  = 2'b00,
    PCMSP_RXCK_LOW  = 2'b01,
    PCMSP_RXCK_HIGH = 2'b11
  } pcmsp_mclk_mode_t;

  typedef enum logic [1:0] {
    PCMSP_SL_IDLE  = 2'b00,
    PCMSP_SL_SHIFT = 2'b01,
    PCMSP_SL_DONE  = 2'b11
  } pcmsp_slot_t;

  typedef struct packed {
    logic tx_bclk;
    logic tx_fs;
    logic rx_bclk;
    logic rx_fs;
    logic rx_din;
    logic tx_mclk;
    logic rx_mclk;
  } pcmsp_pins_t;
endpackage

//--- rtl/pcmsp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pcmsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_comb begin
    wr_d  = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d  = pop  ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // pcmsp_fifo
`default_nettype wire

//--- rtl/pcmsp_port.sv
// PCM codec serial port: transmit/receive shifters, slot indicator, clock modes
// Operation
// - Transmit output driven only in transmit slot
// - Shift transmit bits on bit clock after frame
// - Sample receive bits on falling bit clock after frame
// - Slot indicator pulled low during transmit slot
// - Receive master clock low: use transmit clock
// - Receive master clock high: power down
// - Synchronous mode: rx bit clock selects rate
// - Loopback input high reported on loop_active status
`timescale 1ns/1ns
`default_nettype none
module pcmsp_port
  import pcmsp_pkg::*;
#(
  parameter int   WORD_BITS     = PCMSP_WORD_BITS,
  parameter int   FIFO_DEPTH    = PCMSP_FIFO_DEPTH,
  parameter logic RATE_2048_LVL = 1'b1,
  parameter bit   SYNC_MODE     = 1'b0
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Serial pins
  input  wire logic                 tx_bit_clock,
  input  wire logic                 tx_frame_pulse,
  input  wire logic                 rx_bit_clock,
  input  wire logic                 rx_frame_pulse,
  input  wire logic                 rx_serial_in,
  input  wire logic                 tx_master_clock,
  input  wire logic                 rx_master_clock,
  input  wire logic                 return_path_select,
  output logic                      tx_serial_out_o,
  output logic                      tx_serial_out_oe,
  output logic                      tx_slot_indicator_o,
  output logic                      tx_slot_indicator_oe,
  // Transmit samples from the encoder
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [WORD_BITS-1:0] tx_data,
  // Received samples to the decoder
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic      [WORD_BITS-1:0] rx_data,
  // Status
  output logic                      power_down,
  output logic                      use_tx_master,
  output logic                      rate_2048,
  output logic                      loop_active,
  output logic                      rx_overrun
);
  localparam int BW = $clog2(WORD_BITS + 1);
  localparam int IW = $clog2(PCMSP_MCLK_IDLE_CYC + 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pcmsp_pins_t raw, s1_q, s2_q, s3_q;
  assign raw = '{tx_bclk: tx_bit_clock, tx_fs: tx_frame_pulse, rx_bclk: rx_bit_clock,
                 rx_fs: rx_frame_pulse, rx_din: rx_serial_in,
                 tx_mclk: tx_master_clock, rx_mclk: rx_master_clock};
  logic loop_s1_q, loop_s2_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      loop_s1_q <= 1'b0;
      loop_s2_q <= 1'b0;
    end else begin
      s1_q      <= raw;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      loop_s1_q <= return_path_select;
      loop_s2_q <= loop_s1_q;
    end
  end

  // Clock edges, taken on the second and third stages only; frame pins are read as second-stage levels
  logic txb_rise, txb_fall, rxb_fall, rx_master_clock_edge;
  logic rx_bclk_fall;
  assign txb_rise   = s2_q.tx_bclk && !s3_q.tx_bclk;
  assign txb_fall   = !s2_q.tx_bclk && s3_q.tx_bclk;
  assign rxb_fall   = !s2_q.rx_bclk && s3_q.rx_bclk;
  assign rx_master_clock_edge = s2_q.rx_mclk != s3_q.rx_mclk;
  // Synchronous mode: transmit bit clock times both directions
  assign rx_bclk_fall = SYNC_MODE ? txb_fall : rxb_fall;
  assign loop_active  = loop_s2_q;

  // ---------------------------------------------------------------
  // Receive master clock watch
  // ---------------------------------------------------------------
  // Static-level detection needs a timeout: a slow clock looks static briefly
  logic [IW-1:0]    idle_q, idle_d;
  pcmsp_mclk_mode_t mode_q, mode_d;
  logic             rate_q, rate_d;

  always_comb begin
    idle_d = idle_q;
    mode_d = mode_q;
    if (rx_master_clock_edge) begin
      idle_d = '0;
      mode_d = PCMSP_RXCK_RUN;
    end else if (idle_q != IW'(PCMSP_MCLK_IDLE_CYC)) begin
      idle_d = idle_q + 1'b1;
    end else begin
      mode_d = s2_q.rx_mclk ? PCMSP_RXCK_HIGH : PCMSP_RXCK_LOW;
    end
    rate_d = SYNC_MODE ? (s2_q.rx_bclk == RATE_2048_LVL) : 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_q <= '0;
      mode_q <= PCMSP_RXCK_RUN;
      rate_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      mode_q <= mode_d;
      rate_q <= rate_d;
    end
  end

  assign power_down    = (mode_q == PCMSP_RXCK_HIGH);
  assign use_tx_master = (mode_q == PCMSP_RXCK_LOW);
  assign rate_2048     = rate_q;

  // ---------------------------------------------------------------
  // Transmit slot
  // ---------------------------------------------------------------
  logic        tx_fifo_valid, tx_fifo_pop;
  pcmsp_word_t tx_fifo_data;

  pcmsp_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (tx_fifo_valid),
    .out_ready (tx_fifo_pop),
    .out_data  (tx_fifo_data)
  );

  pcmsp_slot_t tx_st_q, tx_st_d;
  pcmsp_word_t tx_sh_q, tx_sh_d;
  logic [BW-1:0] tx_cnt_q, tx_cnt_d;
  logic        tx_oe_q, tx_oe_d;

  always_comb begin
    tx_st_d     = tx_st_q;
    tx_sh_d     = tx_sh_q;
    tx_cnt_d    = tx_cnt_q;
    tx_oe_d     = tx_oe_q;
    tx_fifo_pop = 1'b0;
    unique case (tx_st_q)
      PCMSP_SL_IDLE: begin
        // Frame pulse seen at a rising bit clock opens the slot
        if (txb_rise && s2_q.tx_fs && !power_down) begin
          tx_st_d     = PCMSP_SL_SHIFT;
          tx_sh_d     = tx_fifo_valid ? tx_fifo_data : PCMSP_TX_RESET;
          tx_fifo_pop = tx_fifo_valid;
          tx_cnt_d    = '0;
          tx_oe_d     = 1'b1;
        end
      end
      PCMSP_SL_SHIFT: begin
        if (txb_rise && tx_cnt_q != '0) begin
          tx_sh_d = {tx_sh_q[WORD_BITS-2:0], 1'b0};
        end
        if (txb_fall) begin
          tx_cnt_d = tx_cnt_q + 1'b1;
          if (tx_cnt_q == BW'(WORD_BITS-1)) begin
            tx_st_d = PCMSP_SL_DONE;
            tx_oe_d = 1'b0;
          end
        end
      end
      PCMSP_SL_DONE: begin
        if (!s2_q.tx_fs) begin
          tx_st_d = PCMSP_SL_IDLE;
        end
      end
      default: begin
        tx_st_d = PCMSP_SL_IDLE;
        tx_oe_d = 1'b0;
      end
    endcase
    if (power_down) begin
      tx_st_d = PCMSP_SL_IDLE;
      tx_oe_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_st_q  <= PCMSP_SL_IDLE;
      tx_sh_q  <= PCMSP_TX_RESET;
      tx_cnt_q <= '0;
      tx_oe_q  <= 1'b0;
    end else begin
      tx_st_q  <= tx_st_d;
      tx_sh_q  <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      tx_oe_q  <= tx_oe_d;
    end
  end

  assign tx_serial_out_o      = tx_sh_q[WORD_BITS-1];
  assign tx_serial_out_oe     = tx_oe_q;
  assign tx_slot_indicator_o  = 1'b0;
  assign tx_slot_indicator_oe = tx_oe_q;

  // ---------------------------------------------------------------
  // Receive slot
  // ---------------------------------------------------------------
  pcmsp_slot_t rx_st_q, rx_st_d;
  pcmsp_word_t rx_sh_q, rx_sh_d;
  logic [BW-1:0] rx_cnt_q, rx_cnt_d;
  logic        rx_push, rx_fifo_ready, rx_ovr_q, rx_ovr_d;
  logic        rx_fs_bit;
  assign rx_fs_bit = SYNC_MODE ? s2_q.tx_fs : s2_q.rx_fs;

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_sh_d  = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    rx_push  = 1'b0;
    rx_ovr_d = rx_ovr_q;
    unique case (rx_st_q)
      PCMSP_SL_IDLE: begin
        if (rx_bclk_fall && rx_fs_bit && !power_down) begin
          rx_st_d  = PCMSP_SL_SHIFT;
          rx_sh_d  = {rx_sh_q[WORD_BITS-2:0], s2_q.rx_din};
          rx_cnt_d = BW'(1);
        end
      end
      PCMSP_SL_SHIFT: begin
        if (rx_bclk_fall) begin
          rx_sh_d  = {rx_sh_q[WORD_BITS-2:0], s2_q.rx_din};
          rx_cnt_d = rx_cnt_q + 1'b1;
          if (rx_cnt_q == BW'(WORD_BITS-1)) begin
            rx_st_d  = PCMSP_SL_DONE;
            rx_push  = 1'b1;
            // Decoder too slow: the word is dropped and flagged
            rx_ovr_d = rx_ovr_q || !rx_fifo_ready;
          end
        end
      end
      PCMSP_SL_DONE: begin
        if (!rx_fs_bit) begin
          rx_st_d = PCMSP_SL_IDLE;
        end
      end
      default: rx_st_d = PCMSP_SL_IDLE;
    endcase
    if (power_down) begin
      rx_st_d = PCMSP_SL_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_st_q  <= PCMSP_SL_IDLE;
      rx_sh_q  <= PCMSP_RX_RESET;
      rx_cnt_q <= '0;
      rx_ovr_q <= 1'b0;
    end else begin
      rx_st_q  <= rx_st_d;
      rx_sh_q  <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      rx_ovr_q <= rx_ovr_d;
    end
  end

  assign rx_overrun = rx_ovr_q;

  pcmsp_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (rx_fifo_ready),
    .in_data   (rx_sh_d),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );
endmodule // pcmsp_port
`default_nettype wire

//--- sim/pcmsp_checker.sv
// Checker: port-level properties of the PCM codec serial port
`timescale 1ns/1ns
`default_nettype none
module pcmsp_checker #(
  parameter logic RATE_2048_LVL = 1'b1,
  parameter bit   SYNC_MODE     = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins
  input wire logic tx_frame_pulse,
  input wire logic rx_bit_clock,
  input wire logic rx_master_clock,
  input wire logic return_path_select,
  // Watched outputs
  input wire logic tx_serial_out_oe,
  input wire logic tx_slot_indicator_o,
  input wire logic tx_slot_indicator_oe,
  input wire logic power_down,
  input wire logic use_tx_master,
  input wire logic rate_2048,
  input wire logic loop_active,
  input wire logic rx_overrun
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Run-length counters
  // ----------------------------------------
  logic [7:0] hi_q, hi_d, lo_q, lo_d, oe_q, oe_d;
  always_comb begin
    hi_d = !rx_master_clock ? 8'h00 : (&hi_q ? hi_q : hi_q + 8'h01);
    lo_d = rx_master_clock ? 8'h00 : (&lo_q ? lo_q : lo_q + 8'h01);
    oe_d = tx_serial_out_oe ? oe_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      oe_q <= 8'h00;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      oe_q <= oe_d;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_ind_mirror: assert property (tx_slot_indicator_oe == tx_serial_out_oe
    && !tx_slot_indicator_o) else $error("slot indicator not tied to slot");
  chk_slot_start: assert property ($rose(tx_serial_out_oe) |-> !power_down
    && $past(tx_frame_pulse, 3)) else $error("output enabled without frame");
  chk_slot_len: assert property ($fell(tx_serial_out_oe) |->
    $past(oe_q) inside {[8'h39:8'h3f]}) else $error("slot length not 8 bits");
  chk_pd_static: assert property ($rose(power_down) |-> hi_q >= 8'h28)
    else $error("power down too early");
  chk_pd_bound: assert property (hi_q == 8'h32 |-> power_down)
    else $error("power down missing");
  chk_txm_static: assert property ($rose(use_tx_master) |-> lo_q >= 8'h28)
    else $error("clock fallback too early");
  chk_txm_bound: assert property (lo_q == 8'h32 |-> use_tx_master && !power_down)
    else $error("clock fallback missing");
  chk_rate_pin: assert property ($stable(rx_bit_clock)[*4] |->
    rate_2048 == (SYNC_MODE && rx_bit_clock == RATE_2048_LVL)) else $error("rate wrong");
  chk_loop_pin: assert property ($stable(return_path_select)[*4] |->
    loop_active == return_path_select) else $error("loopback status wrong");
  chk_ovr_sticky: assert property ($past(rx_overrun) |-> rx_overrun)
    else $error("overrun flag cleared");
  cover property ($fell(tx_serial_out_oe));
  cover property ($rose(power_down));
  cover property ($rose(rx_overrun));
  cover property ($rose(loop_active));
endmodule // pcmsp_checker
bind pcmsp_port pcmsp_checker #(
  .RATE_2048_LVL(RATE_2048_LVL),
  .SYNC_MODE(SYNC_MODE)
) u_chk (
  .mclk, .rst, .tx_frame_pulse, .rx_bit_clock, .rx_master_clock,
  .return_path_select, .tx_serial_out_oe, .tx_slot_indicator_o,
  .tx_slot_indicator_oe, .power_down, .use_tx_master, .rate_2048,
  .loop_active, .rx_overrun
);
`default_nettype wire

//--- sim/pcmsp_host.sv
// Highway controller model: frame pulses, gated bit clock, PCM data
`timescale 1ns/1ns
`default_nettype none
module pcmsp_host
  import pcmsp_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      bclk,
  output logic      fs,
  output logic      din,
  input  wire logic dout
);
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    din = 1'b0;
  end
  // One frame: bit clock stands still outside the slot
  task automatic xfer(input pcmsp_word_t rxw, output pcmsp_word_t txw);
    @(negedge mclk);
    fs = 1'b1;
    repeat (4) @(negedge mclk);
    for (int i = 7; i >= 0; i--) begin
      bclk = 1'b1;
      din = rxw[i];
      repeat (4) @(negedge mclk);
      bclk = 1'b0;
      @(negedge mclk);
      txw[i] = dout;
      repeat (3) @(negedge mclk);
    end
    fs = 1'b0;
    // Released line must not keep the last bit
    din = ~din;
    repeat (1181) @(negedge mclk);
  endtask
endmodule // pcmsp_host
`default_nettype wire

//--- sim/pcmsp_port_tb.sv
// Testbench for the PCM codec serial port
`timescale 1ns/1ns
`default_nettype none
module pcmsp_port_tb;
  import pcmsp_pkg::*;
  localparam pcmsp_word_t TXW [8] = '{8'h80, 8'h01, 8'ha5, 8'h5a,
                                      8'hff, 8'h7e, 8'hc3, 8'h3c};
  logic        mclk = 1'b0, rst = 1'b1, bclk, fs, din, rmk_run = 1'b1;
  logic        tx_master_clock = 1'b0, rx_master_clock = 1'b0;
  logic        return_path_select = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  pcmsp_word_t tx_data = 8'h00;
  logic        tx_serial_out_o, tx_serial_out_oe, tx_slot_indicator_o;
  logic        tx_slot_indicator_oe, tx_ready, rx_valid, power_down;
  logic        use_tx_master, rate_2048, loop_active, rx_overrun;
  pcmsp_word_t rx_data;
  // Second unit in synchronous mode: its rx bit clock pin is the rate strap
  logic        rate_sel = 1'b1, sy_rx_ready = 1'b0, sy_valid, sy_rate, rmk_lvl = 1'b0;
  pcmsp_word_t sy_data;
  wire logic   dx;
  int          error_cnt = 0, check_count = 0;
  assign dx = tx_serial_out_oe ? tx_serial_out_o : 1'bz;
  always #50 mclk = ~mclk;
  // Odd phase offset keeps master clock edges off mclk edges; about 2.048/1.536 MHz
  initial begin
    #25;
    forever #244 tx_master_clock = ~tx_master_clock;
  end
  // Not locked to the transmit master clock on purpose; parks at rmk_lvl when stopped
  initial begin
    #25;
    forever #326 rx_master_clock = rmk_run ? ~rx_master_clock : rmk_lvl;
  end
  pcmsp_port u_dut (
    .mclk, .rst, .tx_bit_clock(bclk), .tx_frame_pulse(fs), .rx_bit_clock(bclk),
    .rx_frame_pulse(fs), .rx_serial_in(din), .tx_master_clock, .rx_master_clock,
    .return_path_select, .tx_serial_out_o, .tx_serial_out_oe, .tx_slot_indicator_o,
    .tx_slot_indicator_oe, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready,
    .rx_data, .power_down, .use_tx_master, .rate_2048, .loop_active, .rx_overrun
  );
  pcmsp_host u_host (.mclk, .bclk, .fs, .din, .dout(dx));
  pcmsp_port #(.SYNC_MODE(1'b1)) u_dut_sync (
    .mclk, .rst, .tx_bit_clock(bclk), .tx_frame_pulse(fs), .rx_bit_clock(rate_sel),
    .rx_frame_pulse(fs), .rx_serial_in(din), .tx_master_clock, .rx_master_clock,
    .return_path_select, .tx_serial_out_o(), .tx_serial_out_oe(),
    .tx_slot_indicator_o(), .tx_slot_indicator_oe(), .tx_valid(1'b0), .tx_ready(),
    .tx_data(8'h00), .rx_valid(sy_valid), .rx_ready(sy_rx_ready), .rx_data(sy_data),
    .power_down(), .use_tx_master(), .rate_2048(sy_rate), .loop_active(), .rx_overrun()
  );
  // ----------------------------------------
  // Compare and finish
  // ----------------------------------------
  task automatic chk_w(input pcmsp_word_t got, input pcmsp_word_t exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk_b(tx_serial_out_oe, 1'b0);
    chk_b(tx_slot_indicator_oe, 1'b0);
    chk_b(tx_ready, 1'b1);
    chk_b(rx_valid, 1'b0);
    chk_b(rate_2048, 1'b0);
  endtask
  task automatic t_loop;
    return_path_select = 1'b1;
    repeat (4) @(negedge mclk);
    chk_b(loop_active, 1'b1);
    return_path_select = 1'b0;
    repeat (4) @(negedge mclk);
    chk_b(loop_active, 1'b0);
  endtask
  // Fill TX FIFO past full, stall RX side into overrun, then drain
  task automatic t_stream;
    pcmsp_word_t w;
    for (int i = 0; i < 9; i++) begin
      tx_valid = 1'b1;
      tx_data = i < 8 ? TXW[i] : 8'h11;
      @(negedge mclk);
    end
    tx_valid = 1'b0;
    chk_b(tx_ready, 1'b0);
    for (int i = 0; i < 9; i++) begin
      chk_b(rx_overrun, 1'b0);
      u_host.xfer(~TXW[i % 8], w);
      chk_w(w, i < 8 ? TXW[i] : 8'h00);
    end
    chk_b(rx_overrun, 1'b1);
    chk_b(tx_serial_out_oe, 1'b0);
    rx_ready = 1'b1;
    for (int i = 0; i < 8; i++) begin
      chk_b(rx_valid, 1'b1);
      chk_w(rx_data, ~TXW[i]);
      @(negedge mclk);
    end
    rx_ready = 1'b0;
    chk_b(rx_valid, 1'b0);
  endtask
  // Synchronous unit took the same frames on transmit timing; strap high picks 2048 group
  task automatic t_sync;
    chk_b(sy_rate, 1'b1);
    rate_sel = 1'b0;
    repeat (4) @(negedge mclk);
    chk_b(sy_rate, 1'b0);
    sy_rx_ready = 1'b1;
    for (int i = 0; i < 8; i++) begin
      chk_b(sy_valid, 1'b1);
      chk_w(sy_data, ~TXW[i]);
      @(negedge mclk);
    end
    sy_rx_ready = 1'b0;
    chk_b(sy_valid, 1'b0);
  endtask
  task automatic t_mclk;
    pcmsp_word_t w;
    rmk_run = 1'b0;
    rmk_lvl = 1'b0;
    repeat (60) @(negedge mclk);
    chk_b(use_tx_master, 1'b1);
    chk_b(power_down, 1'b0);
    rmk_lvl = 1'b1;
    repeat (60) @(negedge mclk);
    chk_b(power_down, 1'b1);
    u_host.xfer(8'h5a, w);
    chk_w(w, 8'hzz);
    rmk_run = 1'b1;
    repeat (60) @(negedge mclk);
    chk_b(power_down, 1'b0);
  endtask
  initial begin
    // About 13k cycles of scenarios; generous margin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_loop();
    t_stream();
    t_sync();
    t_mclk();
    finish_test();
  end
endmodule // pcmsp_port_tb
`default_nettype wire
